// ---- logic/sacp_pkg.sv ----
// package for the sampling converter control port
//
// Contract
// R1: start and read inputs are ignored unless device select is low.
// R2: a falling edge on the active-low start input while selected begins a conversion.
// R3: the approximation register is cleared at the start of each conversion before any bit decision.
// R4: start edges during a conversion neither restart nor abort it.
// R5: busy is low for the whole conversion and high otherwise.
// R6: the new result is already in the output latches when busy rises.
// R7: bits are decided one per step from the most significant down to the least over 12 bits.
// R8: at the end of conversion the whole 12-bit approximation word is loaded into the output latches.
// R9: the result lines are driven only while read and device select are both low.
// R10: the host leaves at least 100 ns of acquisition between the end of one conversion and the next start.
// R11: power-down low puts the device into the shutdown state chosen by the depth select.
// R12: depth select low chooses deep sleep and high chooses quick wake-up nap.
// R13: the result is two's complement binary of the differential input.
// R14: the host returns start high within 425 ns of the start or only after busy rises.
// R15: no conversions in shutdown, and a wake-up interval passes after power-down returns high; a conversion under way at power-down still completes.
package sacp_pkg;
    localparam int           RES_BITS      = 12;
    localparam int           CLK_PERIOD_PS = 25000;
    localparam int           ACQ_MIN_NS    = 100;
    localparam int           WAKE_NS       = 200;
    localparam int           START_HOLD_NS = 425;
    localparam int           WAKE_CYC      = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int           ACQ_CYC       = (ACQ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0]   MSB_IDX       = 4'hB;
    localparam logic [11:0]  SAR_CLEAR     = 12'h000;
    localparam logic [11:0]  SIGN_FLIP     = 12'h800;
    localparam logic [3:0]   WAKE_CNT      = 4'(WAKE_CYC);
    localparam logic [3:0]   BIT_STEPS     = 4'hC;
    localparam logic [3:0]   BUSY_CYC      = 4'hE;

    typedef enum logic [1:0] {
        SACP_IDLE  = 2'b00,
        SACP_CLEAR = 2'b01,
        SACP_BITS  = 2'b10,
        SACP_LOAD  = 2'b11
    } sacp_state_e;

    typedef enum logic [1:0] {
        SACP_AWAKE = 2'b00,
        SACP_NAP   = 2'b01,
        SACP_SLEEP = 2'b10
    } sacp_power_e;

    typedef struct packed {
        logic        busy_n;
        logic [11:0] result;
        logic [11:0] result_oe;
    } sacp_out_s;
endpackage : sacp_pkg

// ---- logic/sacp_sar_step.sv ----
// one successive-approximation step: trial bit and decision
`timescale 1ns/1ps
`default_nettype none
module sacp_sar_step (
    input  wire logic [11:0] sar_i,
    input  wire logic [3:0]  idx_i,
    input  wire logic        cmp_hi_i,
    output logic      [11:0] trial_o,
    output logic      [11:0] decided_o
);
    logic [11:0] bit_mask;

    assign bit_mask  = 12'h001 << idx_i;
    assign trial_o   = sar_i | bit_mask;
    // comparator high keeps the trial bit, else drop it
    assign decided_o = cmp_hi_i ? trial_o : sar_i;
endmodule : sacp_sar_step
`default_nettype wire

// ---- logic/sacp_top.sv ----
// control port of the 12-bit sampling converter
`timescale 1ns/1ps
`default_nettype none
module sacp_top (
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        DEV_SEL_N_I,
    input  wire logic        READ_N_I,
    input  wire logic        CONVERT_START_N_I,
    input  wire logic        POWER_DOWN_N_I,
    input  wire logic        SHUTDOWN_DEPTH_SELECT_I,
    input  wire logic [11:0] ANALOG_CODE_I,
    output logic      [11:0] TRIAL_CODE_O,
    output logic             BUSY_N_O,
    output logic      [11:0] RESULT_BUS_O,
    output logic      [11:0] RESULT_BUS_OE_O,
    output logic             NAP_O,
    output logic             SLEEP_O
);
    sacp_pkg::sacp_state_e state;
    sacp_pkg::sacp_power_e power;
    sacp_pkg::sacp_out_s   outs;
    logic [11:0]           successive_approx_reg;
    logic [11:0]           latch;
    logic [3:0]            idx;
    logic [3:0]            wake;
    logic                  start_q;
    logic                  start_fall;
    logic                  cmp_hi;
    logic [11:0]           trial;
    logic [11:0]           decided;
    logic [11:0]           analog_offset;
    logic                  start_take;
    logic [3:0]            bits_cnt;
    logic [3:0]            busy_run;

    // one decode of an accepted start, shared by the state walk and the busy flop
    function automatic logic take_start(
        input sacp_pkg::sacp_state_e st,
        input sacp_pkg::sacp_power_e pw,
        input logic                  fall_seen,
        input logic                  power_pin_n,
        input logic [3:0]            wake_left
    );
        return st == sacp_pkg::SACP_IDLE && fall_seen && pw == sacp_pkg::SACP_AWAKE
               && power_pin_n && wake_left == 4'h0; // R2 R15
    endfunction : take_start

    // analog code is two's complement; the comparator model works in offset binary
    assign analog_offset = ANALOG_CODE_I ^ sacp_pkg::SIGN_FLIP;
    assign cmp_hi        = (analog_offset >= trial);

    // only a selected falling edge counts, gated by power and wake
    assign start_fall = !DEV_SEL_N_I && start_q && !CONVERT_START_N_I; // R1 R2
    // the pin is looked at too, so a start in the cycle power drops is refused
    assign start_take = take_start(state, power, start_fall, POWER_DOWN_N_I, wake);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            start_q <= 1'b1;
        end else begin
            start_q <= CONVERT_START_N_I;
        end
    end

    sacp_sar_step u_step (
        .sar_i     (successive_approx_reg),
        .idx_i     (idx),
        .cmp_hi_i  (cmp_hi),
        .trial_o   (trial),
        .decided_o (decided)
    );

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            power <= sacp_pkg::SACP_AWAKE;
        end else if (!POWER_DOWN_N_I) begin
            // depth is re-sampled while down so a late select change still applies
            power <= SHUTDOWN_DEPTH_SELECT_I ? sacp_pkg::SACP_NAP : sacp_pkg::SACP_SLEEP; // R11 R12
        end else begin
            power <= sacp_pkg::SACP_AWAKE;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wake <= 4'h0;
        end else if (power != sacp_pkg::SACP_AWAKE) begin
            wake <= sacp_pkg::WAKE_CNT; // R15
        end else if (wake != 4'h0) begin
            wake <= wake - 4'h1;
        end
    end

    // a conversion in flight at power-down completes; only new starts are blocked
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state <= sacp_pkg::SACP_IDLE;
        end else begin
            unique case (state)
                sacp_pkg::SACP_IDLE: begin
                    if (start_take) begin // R2 R15
                        state <= sacp_pkg::SACP_CLEAR;
                    end
                end
                sacp_pkg::SACP_CLEAR: begin
                    state <= sacp_pkg::SACP_BITS;
                end
                sacp_pkg::SACP_BITS: begin
                    if (idx == 4'h0) begin
                        state <= sacp_pkg::SACP_LOAD;
                    end
                end
                sacp_pkg::SACP_LOAD: begin
                    state <= sacp_pkg::SACP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            successive_approx_reg <= sacp_pkg::SAR_CLEAR;
            idx                   <= sacp_pkg::MSB_IDX;
        end else if (state == sacp_pkg::SACP_CLEAR) begin
            successive_approx_reg <= sacp_pkg::SAR_CLEAR; // R3
            idx                   <= sacp_pkg::MSB_IDX;
        end else if (state == sacp_pkg::SACP_BITS) begin
            successive_approx_reg <= decided; // R7
            if (idx != 4'h0) begin
                idx <= idx - 4'h1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            latch <= sacp_pkg::SAR_CLEAR;
        end else if (state == sacp_pkg::SACP_LOAD) begin
            // flip back to two's complement on the way out
            latch <= successive_approx_reg ^ sacp_pkg::SIGN_FLIP; // R8 R13
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            outs <= '{busy_n: 1'b1, result: 12'h000, result_oe: 12'h000};
        end else begin
            outs.busy_n    <= (state == sacp_pkg::SACP_IDLE || state == sacp_pkg::SACP_LOAD)
                              && !start_take; // R4 R5 R6
            // the result flop loads with the latch so it is valid on the edge busy rises
            outs.result    <= (state == sacp_pkg::SACP_LOAD) ? (successive_approx_reg ^ sacp_pkg::SIGN_FLIP)
                              : latch; // R6
            outs.result_oe <= {sacp_pkg::RES_BITS{!READ_N_I && !DEV_SEL_N_I}}; // R1 R9
        end
    end

    assign BUSY_N_O        = outs.busy_n;
    assign RESULT_BUS_O    = outs.result;
    assign RESULT_BUS_OE_O = outs.result_oe;
    assign TRIAL_CODE_O    = trial;
    assign NAP_O           = (power == sacp_pkg::SACP_NAP);
    assign SLEEP_O         = (power == sacp_pkg::SACP_SLEEP);

    // helper counters for the length checks; a long repetition would be costly to unroll
    always_ff @(posedge CLK_I) begin
        if (RST_I || state != sacp_pkg::SACP_BITS) begin
            bits_cnt <= 4'h0;
        end else begin
            bits_cnt <= bits_cnt + 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || BUSY_N_O) begin
            busy_run <= 4'h0;
        end else if (busy_run != 4'hF) begin
            busy_run <= busy_run + 4'h1;
        end
    end

    // busy low during whole conversion: in BITS state busy must be low
    chk_busy_during_conv: assert property (@(posedge CLK_I) disable iff (RST_I) // R5
        (state == sacp_pkg::SACP_BITS) |-> !BUSY_N_O)
        else $error("busy high during conversion");

    chk_busy_rise_data: assert property (@(posedge CLK_I) disable iff (RST_I) // R6
        $rose(BUSY_N_O) |-> (RESULT_BUS_O == latch) && (latch == ($past(successive_approx_reg) ^ sacp_pkg::SIGN_FLIP)))
        else $error("result not valid at busy rise");

    chk_sar_cleared: assert property (@(posedge CLK_I) disable iff (RST_I) // R3
        (state == sacp_pkg::SACP_CLEAR) |=> (successive_approx_reg == sacp_pkg::SAR_CLEAR) && (idx == sacp_pkg::MSB_IDX))
        else $error("approximation register not cleared");

    chk_bits_msb_down: assert property (@(posedge CLK_I) disable iff (RST_I) // R7
        (state == sacp_pkg::SACP_BITS && idx != 4'h0) |=> (idx == $past(idx) - 4'h1))
        else $error("bit order wrong");

    chk_conv_length: assert property (@(posedge CLK_I) disable iff (RST_I) // R4
        (state == sacp_pkg::SACP_CLEAR) |=> (state == sacp_pkg::SACP_BITS) ##12
            (state == sacp_pkg::SACP_LOAD && bits_cnt == sacp_pkg::BIT_STEPS))
        else $error("conversion restarted or cut short");

    chk_load_latch: assert property (@(posedge CLK_I) disable iff (RST_I) // R8
        (state == sacp_pkg::SACP_LOAD) |=> (latch == ($past(successive_approx_reg) ^ sacp_pkg::SIGN_FLIP)))
        else $error("latch not loaded");

    chk_drive_gate: assert property (@(posedge CLK_I) disable iff (RST_I) // R9
        (RESULT_BUS_OE_O != 12'h000) |-> $past(!READ_N_I && !DEV_SEL_N_I))
        else $error("bus driven while not read");

    chk_unselected_start: assert property (@(posedge CLK_I) disable iff (RST_I) // R1
        (state == sacp_pkg::SACP_IDLE && DEV_SEL_N_I) |=> (state == sacp_pkg::SACP_IDLE))
        else $error("start taken while unselected");

    chk_shutdown_block: assert property (@(posedge CLK_I) disable iff (RST_I) // R15
        (state == sacp_pkg::SACP_IDLE && (!POWER_DOWN_N_I || wake != 4'h0)) |=> (state == sacp_pkg::SACP_IDLE))
        else $error("start taken during shutdown or wake-up");

    chk_depth_mode: assert property (@(posedge CLK_I) disable iff (RST_I) // R11 R12
        !POWER_DOWN_N_I |=> (NAP_O == $past(SHUTDOWN_DEPTH_SELECT_I)) && (SLEEP_O == !$past(SHUTDOWN_DEPTH_SELECT_I)))
        else $error("wrong shutdown depth");

    chk_start_taken: assert property (@(posedge CLK_I) disable iff (RST_I) // R2
        start_take |=> (state == sacp_pkg::SACP_CLEAR) && !BUSY_N_O)
        else $error("accepted start did not begin a conversion");

    chk_no_restart: assert property (@(posedge CLK_I) disable iff (RST_I) // R4
        (state == sacp_pkg::SACP_BITS) |=> (state != sacp_pkg::SACP_CLEAR))
        else $error("conversion restarted");

    chk_busy_length: assert property (@(posedge CLK_I) disable iff (RST_I) // R5
        $rose(BUSY_N_O) |-> (busy_run == sacp_pkg::BUSY_CYC))
        else $error("busy low for the wrong length");

    chk_busy_bound: assert property (@(posedge CLK_I) disable iff (RST_I) // R4 R5
        busy_run <= sacp_pkg::BUSY_CYC)
        else $error("busy low too long");

    chk_idle_busy_high: assert property (@(posedge CLK_I) disable iff (RST_I) // R5
        (state == sacp_pkg::SACP_IDLE) |-> BUSY_N_O)
        else $error("busy low while idle");

    chk_bus_released: assert property (@(posedge CLK_I) disable iff (RST_I) // R9
        READ_N_I |=> (RESULT_BUS_OE_O == 12'h000))
        else $error("bus driven without read");

    chk_bus_driven: assert property (@(posedge CLK_I) disable iff (RST_I) // R9
        (!READ_N_I && !DEV_SEL_N_I) |=> (RESULT_BUS_OE_O == 12'hFFF))
        else $error("bus not driven on read");

    chk_unsel_bus: assert property (@(posedge CLK_I) disable iff (RST_I) // R1
        DEV_SEL_N_I |=> (RESULT_BUS_OE_O == 12'h000))
        else $error("bus driven while unselected");

    chk_result_hold: assert property (@(posedge CLK_I) disable iff (RST_I) // R8
        (state != sacp_pkg::SACP_LOAD) |=> $stable(RESULT_BUS_O))
        else $error("result changed outside a load");

    chk_latch_hold: assert property (@(posedge CLK_I) disable iff (RST_I) // R8
        (state != sacp_pkg::SACP_LOAD) |=> $stable(latch))
        else $error("latch changed outside a load");

    chk_load_from_bits: assert property (@(posedge CLK_I) disable iff (RST_I) // R7
        (state == sacp_pkg::SACP_LOAD) |-> ($past(state) == sacp_pkg::SACP_BITS) && ($past(idx) == 4'h0))
        else $error("load before the last bit");

    chk_trial_msb: assert property (@(posedge CLK_I) disable iff (RST_I) // R3 R7
        (state == sacp_pkg::SACP_BITS && idx == sacp_pkg::MSB_IDX) |-> (TRIAL_CODE_O == sacp_pkg::SIGN_FLIP))
        else $error("first trial is not the top bit alone");

    chk_power_up: assert property (@(posedge CLK_I) disable iff (RST_I) // R11
        POWER_DOWN_N_I |=> !NAP_O && !SLEEP_O)
        else $error("shutdown state while powered");

    chk_down_no_busy: assert property (@(posedge CLK_I) disable iff (RST_I) // R15
        (!POWER_DOWN_N_I && state == sacp_pkg::SACP_IDLE) |=> BUSY_N_O)
        else $error("conversion started while powered down");

    chk_wake_load: assert property (@(posedge CLK_I) disable iff (RST_I) // R15
        (power != sacp_pkg::SACP_AWAKE) ##1 (power == sacp_pkg::SACP_AWAKE) |-> (wake == sacp_pkg::WAKE_CNT))
        else $error("wake interval not loaded");

    chk_wake_runs: assert property (@(posedge CLK_I) disable iff (RST_I) // R15
        (power == sacp_pkg::SACP_AWAKE && wake != 4'h0) |=> (wake == $past(wake) - 4'h1))
        else $error("wake interval not counting");

    // a decided bit never changes again; bits not yet reached stay cleared
    for (genvar b = 0; b < sacp_pkg::RES_BITS; b++) begin : g_bit_order
        chk_bit_frozen: assert property (@(posedge CLK_I) disable iff (RST_I) // R7
            (state == sacp_pkg::SACP_BITS && idx < 4'(b)) |=> (successive_approx_reg[b] == $past(successive_approx_reg[b])))
            else $error("decided bit changed");

        chk_bit_pending: assert property (@(posedge CLK_I) disable iff (RST_I) // R3 R7
            (state == sacp_pkg::SACP_BITS && 4'(b) <= idx) |-> !successive_approx_reg[b])
            else $error("undecided bit not clear");
    end

    cov_conversion: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(BUSY_N_O));
    cov_read: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(RESULT_BUS_OE_O[0]));
    cov_nap: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(NAP_O));
    cov_sleep: cover property (@(posedge CLK_I) disable iff (RST_I)
        $rose(SLEEP_O));
    cov_ignored_start: cover property (@(posedge CLK_I) disable iff (RST_I)
        (state == sacp_pkg::SACP_BITS && start_fall));
endmodule : sacp_top
`default_nettype wire

// ---- testbench/sacp_host.sv ----
// host-side model that strobes conversion starts
`timescale 1ns/1ps
`default_nettype none
module sacp_host (
    input  wire logic clk_i,
    input  wire logic busy_n_i,
    output var  logic start_n_o
);
    initial start_n_o = 1'b1;

    // extra adds a second start edge while busy; it must be ignored
    task automatic convert(input bit extra, output bit ok);
        int n;
        @(negedge clk_i) start_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        start_n_o = 1'b1;
        if (extra) begin
            repeat (3) @(negedge clk_i);
            start_n_o = 1'b0;
            @(negedge clk_i) start_n_o = 1'b1;
        end
        n = 0;
        while (busy_n_i !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        ok = (n < 40);
        repeat (sacp_pkg::ACQ_CYC) @(negedge clk_i);
    endtask : convert
endmodule : sacp_host
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the converter control port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    logic        clk = 0, rst = 1, sel_n = 0, rd_n = 1, pd_n = 1, depth = 0;
    logic [11:0] code = 12'h000, res, oe, exp, trial, rise_res = 12'h000;
    logic        busy_q = 1'b1;
    int          base = 0;
    logic        busy_n, nap, sleep;
    wire logic   start_n;
    logic [31:0] seed = 32'h83AE;
    int          fails = 0, checked = 0, run = 0;
    bit          ok;

    always #12.5 clk = ~clk;
    // counts cycles that busy is seen low
    always @(posedge clk) if (busy_n === 1'b0) run <= run + 1;
    // result as seen in the cycle busy rises
    always @(negedge clk) begin
        busy_q <= busy_n;
        if (busy_n === 1'b1 && busy_q === 1'b0) rise_res <= res;
    end

    sacp_top DUT (.CLK_I(clk), .RST_I(rst), .DEV_SEL_N_I(sel_n), .READ_N_I(rd_n),
        .CONVERT_START_N_I(start_n), .POWER_DOWN_N_I(pd_n), .SHUTDOWN_DEPTH_SELECT_I(depth),
        .ANALOG_CODE_I(code), .TRIAL_CODE_O(trial), .BUSY_N_O(busy_n), .RESULT_BUS_O(res),
        .RESULT_BUS_OE_O(oe), .NAP_O(nap), .SLEEP_O(sleep));
    sacp_host host (.clk_i(clk), .busy_n_i(busy_n), .start_n_o(start_n));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // result is the two's complement input code itself
    function automatic logic [11:0] expect_code(input logic [11:0] c);
        return c;
    endfunction : expect_code

    task automatic conv(input logic [11:0] c, input bit extra);
        code = c;
        base = run;
        host.convert(extra, ok);
        `CHK(ok, 1'b1)
    endtask : conv

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 0;
        `CHK(busy_n, 1'b1)
        `CHK(oe, 12'h000)
        `CHK(trial, 12'h800)
        // corner codes first, then random ones
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            exp = (i == 0) ? 12'h800 : (i == 1) ? 12'h7FF : seed[11:0];
            conv(exp, i == 3);
            `CHK(run - base, 14)
            `CHK(res, expect_code(exp))
            `CHK(rise_res, expect_code(exp))
        end
        $display("test conversions done");
        sel_n = 1;
        conv(~exp, 0);
        `CHK(run - base, 0)
        `CHK(res, exp)
        rd_n = 0;
        @(negedge clk) `CHK(oe, 12'h000)
        sel_n = 0;
        @(negedge clk) `CHK(oe, 12'hFFF)
        rd_n = 1;
        @(negedge clk) `CHK(oe, 12'h000)
        $display("test read port done");
        for (int d = 0; d < 2; d++) begin
            depth = d[0];
            pd_n = 0;
            repeat (2) @(negedge clk);
            `CHK(nap, d[0])
            `CHK(sleep, ~d[0])
            conv(12'h123, 0);
            `CHK(run - base, 0)
            pd_n = 1;
            conv(12'h456, 0);
            `CHK(run - base, 0)
            `CHK({nap, sleep}, 2'b00)
            repeat (10) @(negedge clk);
            conv(12'hA5C, 0);
            `CHK(run - base, 14)
            `CHK(res, expect_code(12'hA5C))
            `CHK(rise_res, expect_code(12'hA5C))
        end
        $display("test shutdown done");
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
